// file: rtl/tpc_defs.svh
// Register offsets, field positions, codes and reset values of the timer channel block
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// Byte offsets: standby word, then one 32-byte window per channel
`define TPC_OFS_STANDBY 8'h00
`define TPC_OFS_CTRL 5'h00
`define TPC_OFS_IOC 5'h04
`define TPC_OFS_IER 5'h08
`define TPC_OFS_SR 5'h0c
`define TPC_OFS_CNT 5'h10
`define TPC_OFS_GRA 5'h14
`define TPC_OFS_GRB 5'h18

// Control register fields
`define TPC_CKS 2:0
`define TPC_EXT_EDGE 4:3
`define TPC_CCLR 6:5

// Clock select codes
`define TPC_CKS_DIV1 3'h0
`define TPC_CKS_DIV4 3'h1
`define TPC_CKS_DIV16 3'h2
`define TPC_CKS_DIV64 3'h3
`define TPC_CKS_EXTA 3'h4
`define TPC_CKS_EXTB 3'h5
`define TPC_CKS_EXTC 3'h6

// Prescaler terminal masks
`define TPC_PRE_DIV4 6'h03
`define TPC_PRE_DIV16 6'h0f
`define TPC_PRE_DIV64 6'h3f

// Counter clear sources
`define TPC_CCLR_GRA 2'h1
`define TPC_CCLR_GRB 2'h2

// I/O control nibble: bit 3 picks capture, low bits give level or edge
`define TPC_IO_CAPTURE 3
`define TPC_IO_LVL 1:0
`define TPC_IO_OFF 2'h0
`define TPC_IO_LOW 2'h1
`define TPC_IO_HIGH 2'h2
`define TPC_EDGE_RISE 2'h0
`define TPC_EDGE_FALL 2'h1

// Status and enable bit positions
`define TPC_FLAG_A 0
`define TPC_FLAG_B 1
`define TPC_FLAG_V 2

// Reset values
`define TPC_RST_CTRL 7'h00
`define TPC_RST_IOC 8'h00
`define TPC_RST_IER 3'h0
`define TPC_RST_CNT 16'h0000
`define TPC_RST_GR 16'hffff
`define TPC_COUNT_MAX 16'hffff

`endif

// file: rtl/tpc_pkg.sv
// Types shared by the timer channel block
package tpc_pkg;

	// Register bus phases: first and second access state
	typedef enum logic [2:0] {
		TPC_BUS_IDLE = 3'b001,
		TPC_BUS_FIRST = 3'b010,
		TPC_BUS_SECOND = 3'b100
	} tpc_bus_state_type;

	typedef logic [15:0] tpc_count_type;

endpackage : tpc_pkg

// file: rtl/tpc_edge_detect.sv
// Rise and fall detector for one synchronous pin input
`timescale 1ns/10ps

module tpc_edge_detect (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pin level and its edges
	input wire logic sig_in,
	output logic rise_out,
	output logic fall_out
);

	logic prev;

	// Previous level; pin is already synchronous to the clock
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= 1'b1; // Pins idle high, so reset leaves no false rise
		end else begin
			prev <= sig_in;
		end
	end

	assign rise_out = sig_in & ~prev;
	assign fall_out = ~sig_in & prev;

endmodule : tpc_edge_detect

// file: rtl/tpc_timer.sv
// Two-channel 16-bit timer with compare, capture, clearing and bus contention handling
//
// Notes on behaviour
// - Compare match fires in the last cycle count equals compare, as count updates.
// - On compare match the selected level is driven on the channel pin.
// - No second match until the next counter input clock.
// - A flag clears only by reading it as one, then writing zero.
// - Runs after reset; standby stops it and blocks channel register access.
// - Clear on match resets count in matching cycle; period is value plus one.
// - Clear during count write second state wins; the write is dropped.
// - Count write in its second state wins over an increment.
// - Compare write in its second state suppresses a match, even same value.
// - Capture during read first state returns the captured value.
// - Capture during compare write second state wins; the write is dropped.
// - Overflow together with clear: count clears, overflow flag stays unset.
// - Overflow during count write second state: write kept, no overflow flag.
// - Set flag with its enable bit raises the request until cleared.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "tpc_defs.svh"

module tpc_timer
	import tpc_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic ARST_N_IN,
	// Wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Timer pins: ch1 A, ch1 B, ch2 A, ch2 B
	input wire logic [3:0] TIMER_IO_PIN_IN,
	output logic [3:0] TIMER_IO_PIN_OUT,
	output logic [3:0] TIMER_IO_PIN_OE_N_OUT,
	// Interrupt requests
	output logic [3:0] MATCH_CAPTURE_IRQ_OUT,
	output logic [1:0] OVERFLOW_IRQ_OUT,
	output logic IRQ_OUT
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [1:0] rst_pipe;
	logic rst_n;
	tpc_bus_state_type bus_state;
	tpc_bus_state_type next_bus_state;
	logic req;
	logic in_first;
	logic in_second;
	logic standby;
	logic [5:0] prescale;
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;
	logic [31:0] next_rd_data;
	tpc_count_type cnt_view [CHANNELS];
	tpc_count_type gra_view [CHANNELS];
	tpc_count_type grb_view [CHANNELS];
	logic [6:0] ctrl_view [CHANNELS];
	logic [7:0] ioc_view [CHANNELS];
	logic [2:0] ier_view [CHANNELS];
	logic [2:0] flag_view [CHANNELS];
	logic [2:0] irq_view [CHANNELS];

	// Byte-lane merge of a 16-bit register
	function automatic tpc_count_type merge16(input tpc_count_type old, input logic [31:0] dat,
		input logic [3:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction : merge16

	// Edge pick by a two-bit mode: rise, fall or both
	function automatic logic pick_edge(input logic [1:0] mode, input logic r, input logic f);
		if (mode == `TPC_EDGE_RISE) begin
			pick_edge = r;
		end else if (mode == `TPC_EDGE_FALL) begin
			pick_edge = f;
		end else begin
			pick_edge = r | f;
		end
	endfunction : pick_edge

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	// Async assert, release through two flops
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	////////////////////////////////////////////////////////////////////////////
	// Bus phases: first state, then second state with ack

	assign req = WB_CYC_IN & WB_STB_IN;

	// Idle, first, second; a held request after ack starts a new access
	always_comb begin
		case (bus_state)
			TPC_BUS_IDLE: next_bus_state = req ? TPC_BUS_FIRST : TPC_BUS_IDLE;
			TPC_BUS_FIRST: next_bus_state = TPC_BUS_SECOND;
			TPC_BUS_SECOND: next_bus_state = TPC_BUS_IDLE;
			default: next_bus_state = TPC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= TPC_BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	assign in_first = (bus_state == TPC_BUS_FIRST) & req;
	assign in_second = (bus_state == TPC_BUS_SECOND) & req;
	assign WB_ACK_OUT = in_second;

	// Standby bit stays reachable so software can leave standby
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			standby <= 1'b0;
		end else if (in_second && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == `TPC_OFS_STANDBY) begin
			standby <= WB_DAT_IN[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and pin edges

	// Frozen in standby so the whole unit stops
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 6'h00;
		end else if (!standby) begin
			prescale <= prescale + 6'h01;
		end
	end

	for (genvar p = 0; p < 4; p++) begin : g_pin
		tpc_edge_detect u_edge (
			.clk_in(CLOCK_IN),
			.rst_n_in(rst_n),
			.sig_in(TIMER_IO_PIN_IN[p]),
			.rise_out(pin_rise[p]),
			.fall_out(pin_fall[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		localparam int PA = 2 * c;
		localparam int PB = 2 * c + 1;
		tpc_count_type cnt;
		tpc_count_type gra;
		tpc_count_type grb;
		logic [6:0] ctrl;
		logic [7:0] ioc;
		logic [2:0] ier;
		logic [2:0] flag;
		logic [2:0] seen;
		logic [2:0] flag_set;
		logic [2:0] flag_clr;
		logic pin_a;
		logic pin_b;
		logic hit;
		logic wr_ctrl;
		logic wr_ioc;
		logic wr_ier;
		logic wr_sr;
		logic wr_cnt;
		logic wr_gra;
		logic wr_grb;
		logic rd_sr;
		logic ext_edge;
		logic tick;
		logic match_a;
		logic match_b;
		logic cap_a;
		logic cap_b;
		logic clear;
		logic ovf;

		// Decode of this channel's window; standby blocks it
		assign hit = !standby && WB_ADR_IN[7:5] == 3'(c + 1);
		assign wr_ctrl = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_CTRL;
		assign wr_ioc = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_IOC;
		assign wr_ier = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_IER;
		assign wr_sr = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_SR;
		assign wr_cnt = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_CNT;
		assign wr_gra = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_GRA;
		assign wr_grb = in_second & WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_GRB;
		assign rd_sr = in_first & ~WB_WE_IN & hit & WB_ADR_IN[4:0] == `TPC_OFS_SR;

		// External clock edge on a shared pin, per selected edge
		always_comb begin
			case (ctrl[`TPC_CKS])
				`TPC_CKS_EXTA: ext_edge = pick_edge(ctrl[`TPC_EXT_EDGE], pin_rise[0], pin_fall[0]);
				`TPC_CKS_EXTB: ext_edge = pick_edge(ctrl[`TPC_EXT_EDGE], pin_rise[1], pin_fall[1]);
				`TPC_CKS_EXTC: ext_edge = pick_edge(ctrl[`TPC_EXT_EDGE], pin_rise[2], pin_fall[2]);
				default: ext_edge = 1'b0;
			endcase
		end

		// Counter input clock
		always_comb begin
			case (ctrl[`TPC_CKS])
				`TPC_CKS_DIV1: tick = 1'b1;
				`TPC_CKS_DIV4: tick = (prescale & `TPC_PRE_DIV4) == `TPC_PRE_DIV4;
				`TPC_CKS_DIV16: tick = (prescale & `TPC_PRE_DIV16) == `TPC_PRE_DIV16;
				`TPC_CKS_DIV64: tick = prescale == `TPC_PRE_DIV64;
				default: tick = ext_edge;
			endcase
		end

		// Match only as the equal count is about to move; a compare write masks it
		assign match_a = !standby && tick && cnt == gra && !ioc[`TPC_IO_CAPTURE] && !wr_gra;
		assign match_b = !standby && tick && cnt == grb && !ioc[4 + `TPC_IO_CAPTURE] && !wr_grb;
		assign cap_a = !standby && ioc[`TPC_IO_CAPTURE] &&
			pick_edge(ioc[`TPC_IO_LVL], pin_rise[PA], pin_fall[PA]);
		assign cap_b = !standby && ioc[4 + `TPC_IO_CAPTURE] &&
			pick_edge(ioc[5:4], pin_rise[PB], pin_fall[PB]);

		// Clear source; clearing in the matching cycle gives period N+1
		assign clear = (ctrl[`TPC_CCLR] == `TPC_CCLR_GRA && (match_a || cap_a)) ||
			(ctrl[`TPC_CCLR] == `TPC_CCLR_GRB && (match_b || cap_b));
		// Wrap flags only when neither clear nor count write took the cycle
		assign ovf = !standby && tick && cnt == `TPC_COUNT_MAX && !clear && !wr_cnt;

		// Count: clear beats write, write beats increment
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				cnt <= `TPC_RST_CNT;
			end else if (clear) begin
				cnt <= `TPC_RST_CNT;
			end else if (wr_cnt) begin
				cnt <= merge16(cnt, WB_DAT_IN, WB_SEL_IN);
			end else if (tick && !standby) begin
				cnt <= cnt + 16'h0001;
			end
		end

		// Compare registers: capture beats a write in the same cycle
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				gra <= `TPC_RST_GR;
				grb <= `TPC_RST_GR;
			end else begin
				if (cap_a) begin
					gra <= cnt;
				end else if (wr_gra) begin
					gra <= merge16(gra, WB_DAT_IN, WB_SEL_IN);
				end
				if (cap_b) begin
					grb <= cnt;
				end else if (wr_grb) begin
					grb <= merge16(grb, WB_DAT_IN, WB_SEL_IN);
				end
			end
		end

		// Configuration registers
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				ctrl <= `TPC_RST_CTRL;
				ioc <= `TPC_RST_IOC;
				ier <= `TPC_RST_IER;
			end else begin
				if (wr_ctrl && WB_SEL_IN[0]) begin
					ctrl <= WB_DAT_IN[6:0];
				end
				if (wr_ioc && WB_SEL_IN[0]) begin
					ioc <= WB_DAT_IN[7:0];
				end
				if (wr_ier && WB_SEL_IN[0]) begin
					ier <= WB_DAT_IN[2:0];
				end
			end
		end

		// Flags: set wins over a clear in the same cycle
		assign flag_set = {ovf, match_b | cap_b, match_a | cap_a};
		assign flag_clr = (wr_sr && WB_SEL_IN[0]) ? (seen & ~WB_DAT_IN[2:0]) : 3'h0;
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				flag <= 3'h0;
			end else begin
				flag <= flag_set | (flag & ~flag_clr);
			end
		end

		// Bits read as one arm the clear; any status write disarms
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				seen <= 3'h0;
			end else if (rd_sr) begin
				seen <= flag;
			end else if (wr_sr) begin
				seen <= 3'h0;
			end
		end

		// Pin levels on compare match: low, high or toggle
		always_ff @(posedge CLOCK_IN or negedge rst_n) begin
			if (!rst_n) begin
				pin_a <= 1'b0;
				pin_b <= 1'b0;
			end else begin
				if (match_a) begin
					case (ioc[`TPC_IO_LVL])
						`TPC_IO_LOW: pin_a <= 1'b0;
						`TPC_IO_HIGH: pin_a <= 1'b1;
						`TPC_IO_OFF: pin_a <= pin_a;
						default: pin_a <= ~pin_a;
					endcase
				end
				if (match_b) begin
					case (ioc[5:4])
						`TPC_IO_LOW: pin_b <= 1'b0;
						`TPC_IO_HIGH: pin_b <= 1'b1;
						`TPC_IO_OFF: pin_b <= pin_b;
						default: pin_b <= ~pin_b;
					endcase
				end
			end
		end

		// Drive only in compare-output mode; shared clock pins stay inputs otherwise
		assign TIMER_IO_PIN_OUT[PA] = pin_a;
		assign TIMER_IO_PIN_OUT[PB] = pin_b;
		assign TIMER_IO_PIN_OE_N_OUT[PA] = ioc[`TPC_IO_CAPTURE] | (ioc[`TPC_IO_LVL] == `TPC_IO_OFF);
		assign TIMER_IO_PIN_OE_N_OUT[PB] = ioc[4 + `TPC_IO_CAPTURE] | (ioc[5:4] == `TPC_IO_OFF);

		// Views for the read mux; a capture in this cycle is already visible
		assign cnt_view[c] = cnt;
		assign gra_view[c] = cap_a ? cnt : gra;
		assign grb_view[c] = cap_b ? cnt : grb;
		assign ctrl_view[c] = ctrl;
		assign ioc_view[c] = ioc;
		assign ier_view[c] = ier;
		assign flag_view[c] = flag;
		assign irq_view[c] = flag & ier;
		assign MATCH_CAPTURE_IRQ_OUT[2 * c] = irq_view[c][`TPC_FLAG_A];
		assign MATCH_CAPTURE_IRQ_OUT[2 * c + 1] = irq_view[c][`TPC_FLAG_B];
		assign OVERFLOW_IRQ_OUT[c] = irq_view[c][`TPC_FLAG_V];
	end

	// One level request for all sources; stays set across standby
	assign IRQ_OUT = |{MATCH_CAPTURE_IRQ_OUT, OVERFLOW_IRQ_OUT};

	////////////////////////////////////////////////////////////////////////////
	// Read data

	// Unmapped or blocked addresses read zero
	always_comb begin
		int ch;
		ch = int'(WB_ADR_IN[7:5]) - 1;
		next_rd_data = 32'h0000_0000;
		if (WB_ADR_IN == `TPC_OFS_STANDBY) begin
			next_rd_data = {31'h0000_0000, standby};
		end else if (!standby && ch >= 0 && ch < CHANNELS) begin
			case (WB_ADR_IN[4:0])
				`TPC_OFS_CTRL: next_rd_data = {25'h000_0000, ctrl_view[ch]};
				`TPC_OFS_IOC: next_rd_data = {24'h00_0000, ioc_view[ch]};
				`TPC_OFS_IER: next_rd_data = {29'h0000_0000, ier_view[ch]};
				`TPC_OFS_SR: next_rd_data = {29'h0000_0000, flag_view[ch]};
				`TPC_OFS_CNT: next_rd_data = {16'h0000, cnt_view[ch]};
				`TPC_OFS_GRA: next_rd_data = {16'h0000, gra_view[ch]};
				`TPC_OFS_GRB: next_rd_data = {16'h0000, grb_view[ch]};
				default: next_rd_data = 32'h0000_0000;
			endcase
		end
	end

	// Sampled at the end of the first state, held through ack
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			WB_DAT_OUT <= 32'h0000_0000;
		end else if (in_first && !WB_WE_IN) begin
			WB_DAT_OUT <= next_rd_data;
		end
	end

endmodule : tpc_timer

// file: verification/tpc_timer_props.sv
// Port-level checker for the timer channel block
`timescale 1ns/10ps

module tpc_timer_props (
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic ARST_N_IN,
	// Bus
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	// Pins and requests
	input wire logic [3:0] TIMER_IO_PIN_OE_N_OUT,
	input wire logic [3:0] MATCH_CAPTURE_IRQ_OUT,
	input wire logic [1:0] OVERFLOW_IRQ_OUT,
	input wire logic IRQ_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!ARST_N_IN);

	////////////////////////////////////////////////////////////////
	// Request seen this cycle
	wire logic req = WB_CYC_IN && WB_STB_IN;
	wire logic wr_ack = WB_ACK_OUT && WB_WE_IN;

	// Fresh request; answer two cycles later, for one cycle
	sequence req_start;
		req && !$past(req);
	endsequence
	sequence ack_pulse;
		WB_ACK_OUT ##1 !WB_ACK_OUT;
	endsequence

	////////////////////////////////////////////////////////////////
	a_ack_one_wait: assert property (req_start |-> !WB_ACK_OUT ##1 !WB_ACK_OUT ##1 ack_pulse)
		else $error("ack timing off");
	a_ack_needs_req: assert property (!req |-> !WB_ACK_OUT) else $error("ack without request");
	a_irq_is_or: assert property (IRQ_OUT == (|{MATCH_CAPTURE_IRQ_OUT, OVERFLOW_IRQ_OUT}))
		else $error("summary request mismatch");
	a_mci_fall_write: assert property (|($past(MATCH_CAPTURE_IRQ_OUT) & ~MATCH_CAPTURE_IRQ_OUT) |-> $past(wr_ack))
		else $error("match request dropped on its own");
	a_ovf_fall_write: assert property (|($past(OVERFLOW_IRQ_OUT) & ~OVERFLOW_IRQ_OUT) |-> $past(wr_ack))
		else $error("overflow request dropped on its own");
	a_irq_holds: assert property (IRQ_OUT && !wr_ack |=> IRQ_OUT) else $error("request fell without write");
	a_oe_by_write: assert property ($changed(TIMER_IO_PIN_OE_N_OUT) |-> $past(wr_ack))
		else $error("pin enable moved without write");
	a_dat_by_read: assert property ($changed(WB_DAT_OUT) |-> $past(req && !WB_WE_IN && !WB_ACK_OUT))
		else $error("read data moved outside a read");
endmodule : tpc_timer_props

bind tpc_timer tpc_timer_props u_props (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.TIMER_IO_PIN_OE_N_OUT(TIMER_IO_PIN_OE_N_OUT), .MATCH_CAPTURE_IRQ_OUT(MATCH_CAPTURE_IRQ_OUT),
	.OVERFLOW_IRQ_OUT(OVERFLOW_IRQ_OUT), .IRQ_OUT(IRQ_OUT));

// file: verification/tpc_pin_model.sv
// Far-side pin model: resolves each shared timer pin from block and external driver
`timescale 1ns/10ps

module tpc_pin_model (
	// Block side
	input wire logic [3:0] pin_out_in,
	input wire logic [3:0] pin_oe_n_in,
	// External clock source side
	input wire logic [3:0] ext_level_in,
	input wire logic [3:0] ext_oe_n_in,
	// Resolved levels
	output logic [3:0] pin_level_out,
	output logic clash_out
);
	////////////////////////////////////////////////////////////////
	// Pull-up when nobody drives, so a released pin never shows stale data
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level_out[i] = !pin_oe_n_in[i] ? pin_out_in[i] : (!ext_oe_n_in[i] ? ext_level_in[i] : 1'b1);
		end
	end

	// Compare output and clock input must never share a pin
	assign clash_out = |(~pin_oe_n_in & ~ext_oe_n_in);
endmodule : tpc_pin_model

// file: verification/tpc_timer_tb.sv
// Self-checking bench for the timer: bus, compare, contention, interrupts, standby
`timescale 1ns/10ps

module tpc_timer_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic [31:0] rd;
	logic ack;
	logic irq;
	logic clash;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] oe_n;
	logic [3:0] mci;
	logic [1:0] ovf;
	logic [3:0] ext_lvl = 4'h0;
	logic [3:0] ext_oe_n = 4'hf;
	int failures = 0;
	int checks_done = 0;
	int cyc_n = 0;
	int t0;
	int t1;
	// Reset contents: address, then expected read
	localparam logic [39:0] ROWS [0:9] = '{{8'h00, 32'h0}, {8'h20, 32'h0}, {8'h24, 32'h0}, {8'h28, 32'h0},
		{8'h2c, 32'h0}, {8'h34, 32'hffff}, {8'h38, 32'hffff}, {8'h48, 32'h0}, {8'h58, 32'hffff}, {8'hfc, 32'h0}};

	always #10 clk = ~clk;
	always @(posedge clk) cyc_n <= cyc_n + 1;

	tpc_timer dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
		.WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack),
		.TIMER_IO_PIN_IN(pin_in), .TIMER_IO_PIN_OUT(pin_out), .TIMER_IO_PIN_OE_N_OUT(oe_n),
		.MATCH_CAPTURE_IRQ_OUT(mci), .OVERFLOW_IRQ_OUT(ovf), .IRQ_OUT(irq));
	tpc_pin_model far (.pin_out_in(pin_out), .pin_oe_n_in(oe_n), .ext_level_in(ext_lvl), .ext_oe_n_in(ext_oe_n),
		.pin_level_out(pin_in), .clash_out(clash));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One classic cycle; ack sampled at rising edges, the watchdog bounds the wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_w <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		// Data taken at the ack edge, then the request drops
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wait_mci(output int t);
		int n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (mci[0] !== 1'b1 && n < 100);
		t = cyc_n;
		if (n >= 100) failures++;
	endtask : wait_mci

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge clk);
		check(32'(oe_n), 32'hf);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			wb(1'b0, ROWS[i][39:32], 32'h0);
			check(rd, ROWS[i][31:0]);
		end
		$display("reset values done");
		// Same-value compare write lands on its match cycle
		wb(1'b1, 8'h58, 32'h0110);
		wb(1'b1, 8'h50, 32'h0100);
		repeat (13) @(posedge clk); // Second state meets count 0x110
		wb(1'b1, 8'h58, 32'h0110);
		wb(1'b0, 8'h4c, 32'h0);
		check(rd & 32'h2, 32'h0);
		// Count write lands on the wrapping increment
		wb(1'b1, 8'h50, 32'hfff0);
		repeat (12) @(posedge clk); // Second state meets count 0xffff
		wb(1'b1, 8'h50, 32'h1234);
		wb(1'b0, 8'h50, 32'h0);
		check(rd, 32'h1236);
		wb(1'b0, 8'h4c, 32'h0);
		check(rd & 32'h4, 32'h0);
		$display("write contention done");
		// Plain wrap: masked, enabled, blind write, read then write
		wb(1'b1, 8'h50, 32'hfff8);
		repeat (12) @(posedge clk);
		check(32'(ovf[1]), 32'h0);
		wb(1'b1, 8'h48, 32'h4);
		@(negedge clk);
		check(32'(ovf[1]), 32'h1);
		wb(1'b1, 8'h4c, 32'h0);
		@(negedge clk);
		check(32'(irq), 32'h1);
		wb(1'b0, 8'h4c, 32'h0);
		check(rd & 32'h4, 32'h4);
		wb(1'b1, 8'h4c, 32'h0);
		@(negedge clk);
		check(32'(irq), 32'h0);
		$display("overflow interrupt done");
		// Match on A with clear: high level on pin, period of six
		wb(1'b1, 8'h20, 32'h7);
		wb(1'b1, 8'h34, 32'h5);
		wb(1'b1, 8'h24, 32'h2);
		wb(1'b1, 8'h28, 32'h1);
		wb(1'b1, 8'h30, 32'h0);
		check(32'(oe_n[0]), 32'h0);
		wb(1'b1, 8'h20, 32'h20);
		wait_mci(t0);
		check(32'(pin_in[0]), 32'h1);
		wb(1'b0, 8'h2c, 32'h0);
		check(rd & 32'h1, 32'h1);
		repeat (3) @(posedge clk);
		wb(1'b1, 8'h2c, 32'h0);
		@(negedge clk);
		check(32'(mci[0]), 32'h0);
		wait_mci(t1);
		// Two periods of six after the flag clear
		check(32'(t1 - t0), 32'hc);
		// Wrap and clear in one cycle
		wb(1'b1, 8'h34, 32'hffff);
		wb(1'b0, 8'h2c, 32'h0);
		wb(1'b1, 8'h2c, 32'h0);
		wb(1'b1, 8'h30, 32'hfff0);
		repeat (20) @(posedge clk);
		wb(1'b0, 8'h2c, 32'h0);
		check(rd & 32'h5, 32'h1);
		check(32'({ovf, mci}), 32'h1);
		$display("compare and clear done");
		// External clock C, each level held two states
		wb(1'b1, 8'h40, 32'h6);
		wb(1'b1, 8'h50, 32'h0);
		ext_oe_n[2] <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (2) @(posedge clk);
			ext_lvl[2] <= ~ext_lvl[2];
		end
		repeat (4) @(posedge clk);
		wb(1'b0, 8'h50, 32'h0);
		check(rd, 32'h4);
		check(32'(clash), 32'h0);
		// Capture on ch2 pin B meets a compare write, then a compare read
		wb(1'b1, 8'h40, 32'h0);
		wb(1'b1, 8'h44, 32'h80);
		ext_oe_n[3] <= 1'b0;
		wb(1'b1, 8'h50, 32'h0);
		fork
			wb(1'b1, 8'h58, 32'h777);
			begin
				repeat (3) @(posedge clk);
				ext_lvl[3] <= 1'b1; // Rise in the write's second state
			end
		join
		wb(1'b0, 8'h58, 32'h0);
		check(rd, 32'h3);
		ext_lvl[3] <= 1'b0;
		fork
			wb(1'b0, 8'h58, 32'h0);
			begin
				repeat (2) @(posedge clk);
				ext_lvl[3] <= 1'b1; // Rise in the read's first state
			end
		join
		check(rd, 32'ha);
		check(32'(clash), 32'h0);
		$display("capture contention done");
		// Standby hides channel registers and drops writes
		wb(1'b1, 8'h28, 32'h0);
		wb(1'b1, 8'h48, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b0, 8'h34, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, 8'h34, 32'h1);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b0, 8'h34, 32'h0);
		check(rd, 32'hffff);
		$display("clock input and standby done");
		// Reset in mid-run quiets pins and a live request; registers return to reset values
		wb(1'b1, 8'h28, 32'h1);
		@(negedge clk);
		check(32'(irq), 32'h1);
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		check(32'(oe_n), 32'hf);
		check(32'(irq), 32'h0);
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		wb(1'b0, 8'h24, 32'h0);
		check(rd, 32'h0);
		$display("second reset done");
		summarize();
	end
endmodule : tpc_timer_tb
